// [verilog/async_serial_transmitter.sv]
// Asynchronous NRZ serial transmitter with holding buffer and baud generator.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps

module async_serial_transmitter (
  input  wire logic                   sys_clk_i,
  input  wire logic                   resetn_i,
  input  wire logic                   ce_i,
  input  wire tx_serial_pkg::reg_req_s reg_req_i,
  output logic [7:0]                  reg_rdata_o,
  output logic                        tx_pin_o,
  output logic                        tx_pin_oe_o,
  output logic                        tx_irq_o
);
  import tx_serial_pkg::*;

  // The register port sets up the mode and baud rate, one holding buffer
  // queues the next character, and a four-state sequencer shifts the current
  // character out on a registered line. All state is frozen while ce_i is low.

  // Software visible control registers. Each one is a plain byte; the status
  // bits that hardware owns are merged in on the read path, over whatever is stored here.
  logic [7:0]  txsc_q;
  logic [7:0]  rxsc_q;
  logic [7:0]  baudc_q;
  logic [7:0]  div_lo_q;
  logic [7:0]  div_hi_q;
  logic [7:0]  irqc_q;
  logic [7:0]  rdata_q;

  // Holding buffer and shifter state. The buffer keeps one queued character,
  // so software may write the next one while the current one is on the line.
  logic        hold_full_q;
  logic [8:0]  hold_data_q;
  logic [8:0]  shift_q;
  logic [3:0]  bit_cnt_q;
  logic [3:0]  bits_q;
  tx_state_e   state_q;
  logic        line_q;
  logic        flag_q;

  // Baud generator state. The prescaler runs first and the divisor counter
  // steps once per prescaler wrap.
  logic [5:0]  presc_q;
  logic [15:0] div_cnt_q;

  // Decoded controls and events. All of them are plain combinational terms of
  // the registers above and of the request on the register port.
  logic        port_on;
  logic        active;
  logic        nine_bit;
  logic        wr_hold;
  logic        load_now;
  logic        take;
  logic        tick;
  logic        presc_wrap;
  logic        restart;
  logic [5:0]  presc_last;
  logic [15:0] div_value;
  logic [8:0]  wr_char;

  // Mode decode: only asynchronous operation with both enables transmits.
  // Clocked mode is not built, so selecting it simply parks the transmitter.
  // Any of the three bits going the wrong way also aborts a frame in flight.
  // Transmit enable gating.
  assign port_on  = rxsc_q[RXSC_PORT_ENABLE];
  assign active   = port_on && txsc_q[TXSC_TX_ENABLE] && !txsc_q[TXSC_CLOCKED_MODE];
  assign nine_bit = txsc_q[TXSC_NINE_BIT_TX];

  // A holding write is accepted when transmitting and the buffer is free.
  // A write that finds the buffer full is dropped rather than overwriting the
  // queued character, and a write while inactive is dropped as well.
  // Holding write accepted.
  assign wr_hold  = reg_req_i.we && (reg_req_i.addr == ADDR_TX_HOLDING_DATA)
                    && active && !hold_full_q;
  // An idle sequencer takes the written character straight away.
  assign load_now = wr_hold && (state_q == ST_IDLE);
  // No hardware parity.
  // The ninth bit is whatever software left in the control register, so any
  // parity must be worked out by the writer and placed there beforehand.
  assign wr_char  = {txsc_q[TXSC_NINTH_BIT], reg_req_i.wdata};
  assign take     = (state_q == ST_STOP) && tick && hold_full_q;

  // Prescale and divisor width selection for the bit clock.
  // The narrow divisor ignores the high byte entirely, so a stale high byte
  // left over from a wide setting cannot stretch the bit period.
  // The divisor value itself is chosen by software; no rate arithmetic is here.
  // Divisor qualification.
  always_comb begin
    div_value = baudc_q[BAUD_DIVISOR_WIDE] ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
    if (baudc_q[BAUD_DIVISOR_WIDE] && txsc_q[TXSC_HIGH_SPEED]) begin
      presc_last = PRESC_FAST;
    end else if (baudc_q[BAUD_DIVISOR_WIDE] || txsc_q[TXSC_HIGH_SPEED]) begin
      presc_last = PRESC_MID;
    end else begin
      presc_last = PRESC_SLOW;
    end
  end

  // Bit clock events. A tick marks the end of one bit period; the counters
  // restart whenever the sequencer is idle so the first bit of a frame is full.
  // Full-length first bit.
  assign presc_wrap = (presc_q == presc_last);
  assign tick       = presc_wrap && (div_cnt_q == 16'h0000);
  assign restart    = load_now || !active || (state_q == ST_IDLE);

  // Control register writes; the flag is never written, the shifter status is written like any other bit.
  // The shifter-empty position of the status byte is stored but never read
  // back, because the read path overrides it with the live sequencer state.
  // Writes to the interrupt status index and to unmapped indices are ignored.
  // Read-only flag bits.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // All control bits come up cleared, so the port starts released and idle.
      txsc_q   <= RESET_BYTE;
      rxsc_q   <= RESET_BYTE;
      baudc_q  <= RESET_BYTE;
      div_lo_q <= RESET_BYTE;
      div_hi_q <= RESET_BYTE;
      irqc_q   <= RESET_BYTE;
    end else if (ce_i && reg_req_i.we) begin
      case (reg_req_i.addr)
        ADDR_TX_STATUS_CONTROL: begin
          txsc_q <= reg_req_i.wdata;
        end
        ADDR_RX_STATUS_CONTROL: begin
          rxsc_q <= reg_req_i.wdata;
        end
        ADDR_BAUD_CONTROL: begin
          baudc_q <= reg_req_i.wdata;
        end
        ADDR_DIVISOR_LOW: begin
          div_lo_q <= reg_req_i.wdata;
        end
        ADDR_DIVISOR_HIGH: begin
          div_hi_q <= reg_req_i.wdata;
        end
        ADDR_IRQ_CONTROL: begin
          irqc_q <= reg_req_i.wdata;
        end
        default: begin
          // Unmapped and read-only indices leave every register as it is.
          irqc_q <= irqc_q;
        end
      endcase
    end
  end

  // Read data register, valid in the cycle after the read strobe only.
  // The register returns to zero in every other cycle with ce_i high, so a master that looks
  // one cycle too late sees zero rather than a stale value.
  // Shifter-empty polled only.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= READ_ZERO;
    end else if (ce_i) begin
      rdata_q <= READ_ZERO;
      if (reg_req_i.re) begin
        case (reg_req_i.addr)
          ADDR_TX_STATUS_CONTROL: begin
            rdata_q                     <= txsc_q;
            // Live shifter-empty status.
            // The later assignment wins, so the stored bit never shows.
            rdata_q[TXSC_SHIFTER_EMPTY] <= (state_q == ST_IDLE);
          end
          ADDR_RX_STATUS_CONTROL: begin
            rdata_q <= rxsc_q;
          end
          ADDR_BAUD_CONTROL: begin
            rdata_q <= baudc_q;
          end
          ADDR_DIVISOR_LOW: begin
            rdata_q <= div_lo_q;
          end
          ADDR_DIVISOR_HIGH: begin
            rdata_q <= div_hi_q;
          end
          ADDR_IRQ_CONTROL: begin
            rdata_q <= irqc_q;
          end
          ADDR_IRQ_STATUS: begin
            // Only the flag position is implemented; the rest reads zero.
            rdata_q[IRQS_TX_EMPTY] <= flag_q;
          end
          default: begin
            rdata_q <= READ_ZERO;
          end
        endcase
      end
    end
  end

  // Baud generator: one tick per bit period, restarted at each idle load.
  // A bit lasts (divisor + 1) prescaler wraps, and a prescaler wrap lasts the
  // selected prescale count plus one clock. Changing the divisor while a frame
  // is on the line takes effect at the next reload of the divisor counter.
  // Baud rate generator.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      presc_q   <= 6'h00;
      div_cnt_q <= 16'h0000;
    end else if (ce_i) begin
      if (restart) begin
        // Idle or a fresh load: start a whole bit period from scratch.
        presc_q   <= 6'h00;
        div_cnt_q <= div_value;
      end else if (presc_wrap) begin
        // The divisor counter steps once per wrap and reloads after zero.
        presc_q   <= 6'h00;
        div_cnt_q <= (div_cnt_q == 16'h0000) ? div_value : div_cnt_q - 16'h0001;
      end else begin
        presc_q <= presc_q + 6'h01;
      end
    end
  end

  // Holding buffer: filled by a write while busy, emptied by the shifter.
  // A take and a new write never meet in one cycle, because a write is only
  // accepted while the buffer is empty and a take needs it full.
  // Dropping out of the active mode discards a queued character.
  // Queue until stop bit.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_full_q <= 1'b0;
      hold_data_q <= 9'h000;
    end else if (ce_i) begin
      if (!active) begin
        hold_full_q <= 1'b0;
      end else if (take) begin
        // The sequencer takes the queued character as the stop bit ends.
        hold_full_q <= 1'b0;
      end else if (wr_hold && !load_now) begin
        // Written while busy: keep it for the next frame.
        hold_full_q <= 1'b1;
        hold_data_q <= wr_char;
      end
    end
  end

  // Transmit sequencer and line driver.
  // The line is a flip-flop, so it changes only on a clock edge and never
  // glitches between bits of equal value. A queued character starts on the
  // very edge that ends the stop bit, so there is no idle gap between frames.
  // Only one stop bit is ever sent.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q   <= ST_IDLE;
      shift_q   <= 9'h000;
      bit_cnt_q <= 4'h0;
      bits_q    <= BITS_EIGHT;
      line_q    <= 1'b1;
    end else if (ce_i) begin
      if (!active) begin
        // Port disable returns sequencer to idle.
        // The shift register and counters keep their contents; they are
        // reloaded at the next start, so only state and line need clearing.
        state_q <= ST_IDLE;
        line_q  <= 1'b1;
      end else begin
        case (state_q)
          ST_IDLE: begin
            // Idle at mark.
            // Nothing to send: keep the line at mark.
            line_q <= 1'b1;
            if (load_now) begin
              shift_q   <= wr_char;
              bits_q    <= nine_bit ? BITS_NINE : BITS_EIGHT;
              bit_cnt_q <= 4'h0;
              line_q    <= 1'b0;
              state_q   <= ST_START;
            end
          end
          ST_START: begin
            // One period per bit.
            // The start bit has been on the line since the load edge.
            if (tick) begin
              line_q  <= shift_q[0];
              state_q <= ST_DATA;
            end
          end
          ST_DATA: begin
            if (tick) begin
              // Eight or nine data bits.
              // The counter holds the index of the data bit now on the line; after the last
              // one the stop bit goes out instead of another shift.
              if (bit_cnt_q == bits_q - 4'h1) begin
                line_q  <= 1'b1;
                state_q <= ST_STOP;
              end else begin
                line_q    <= shift_q[1];
                shift_q   <= {1'b0, shift_q[8:1]};
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_STOP: begin
            if (tick) begin
              if (hold_full_q) begin
                shift_q   <= hold_data_q;
                bits_q    <= nine_bit ? BITS_NINE : BITS_EIGHT;
                bit_cnt_q <= 4'h0;
                line_q    <= 1'b0;
                state_q   <= ST_START;
              end else begin
                // Nothing queued: the line stays at mark from here on.
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            // Unused encodings fall back to idle at mark.
            state_q <= ST_IDLE;
            line_q  <= 1'b1;
          end
        endcase
      end
    end
  end

  // Buffer-empty flag follows buffer state while the transmitter is active, independent of the interrupt enable.
  // It is registered, so it trails the holding buffer by one clock: a read
  // issued right after a holding write may still show the old value.
  // One-cycle update lag.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_q <= 1'b0;
    end else if (ce_i) begin
      flag_q <= active && !hold_full_q;
    end
  end

  // Outputs: the pin is driven whenever the port is on.
  // With the port off the pin is released to the surrounding pad logic.
  // The interrupt is a level that needs all three enables and the flag.
  // Pin output enable.
  assign tx_pin_oe_o = port_on;
  assign tx_pin_o    = line_q;
  assign reg_rdata_o = rdata_q;
  assign tx_irq_o    = flag_q && irqc_q[IRQC_TX] && irqc_q[IRQC_GLOBAL]
                       && irqc_q[IRQC_PERIPH];

endmodule

// [verilog/tx_serial_pkg.sv]
// Shared constants and types of the asynchronous serial transmitter.
package tx_serial_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_TX_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_RX_STATUS_CONTROL = 4'h1;
  localparam logic [3:0] ADDR_BAUD_CONTROL      = 4'h2;
  localparam logic [3:0] ADDR_DIVISOR_LOW       = 4'h3;
  localparam logic [3:0] ADDR_DIVISOR_HIGH      = 4'h4;
  localparam logic [3:0] ADDR_TX_HOLDING_DATA   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CONTROL       = 4'h6;
  localparam logic [3:0] ADDR_IRQ_STATUS        = 4'h7;

  // Bit positions in tx_status_control.
  localparam int TXSC_CLOCKED_MASTER = 7;
  localparam int TXSC_NINE_BIT_TX    = 6;
  localparam int TXSC_TX_ENABLE      = 5;
  localparam int TXSC_CLOCKED_MODE   = 4;
  localparam int TXSC_SEND_BREAK     = 3;
  localparam int TXSC_HIGH_SPEED     = 2;
  localparam int TXSC_SHIFTER_EMPTY  = 1;
  localparam int TXSC_NINTH_BIT      = 0;
  // Bit positions in rx_status_control, baud_control and the interrupt registers.
  localparam int RXSC_PORT_ENABLE    = 7;
  localparam int BAUD_DIVISOR_WIDE   = 3;
  localparam int IRQC_GLOBAL         = 7;
  localparam int IRQC_PERIPH         = 6;
  localparam int IRQC_TX             = 4;
  localparam int IRQS_TX_EMPTY       = 4;

  // Reset values.
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // Baud prescale terminal counts: divide by 64, 16 or 4.
  localparam logic [5:0] PRESC_SLOW  = 6'h3f;
  localparam logic [5:0] PRESC_MID   = 6'h0f;
  localparam logic [5:0] PRESC_FAST  = 6'h03;

  // Data bits per character.
  localparam logic [3:0] BITS_EIGHT  = 4'h8;
  localparam logic [3:0] BITS_NINE   = 4'h9;

  // Transmit sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_DATA  = 2'b10,
    ST_STOP  = 2'b11
  } tx_state_e;

  // One register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_s;

endpackage

// [tb/tx_serial_sva.sv]
// Checker of the serial transmitter port behaviour.
`timescale 1ns/1ps
module tx_serial_sva
  import tx_serial_pkg::*;
(
  input wire logic                     sys_clk_i,
  input wire logic                     resetn_i,
  input wire logic                     ce_i,
  input wire tx_serial_pkg::reg_req_s  reg_req_i,
  input wire logic [7:0]               reg_rdata_o,
  input wire logic                     tx_pin_o,
  input wire logic                     tx_pin_oe_o,
  input wire logic                     tx_irq_o
);
  logic [7:0] irqc_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Shadows the interrupt enables that software writes.
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irqc_q <= 8'h00;
    end else if (ce_i && reg_req_i.we && reg_req_i.addr == ADDR_IRQ_CONTROL) begin
      irqc_q <= reg_req_i.wdata;
    end
  end
  sequence rd_s(a);
    ce_i && reg_req_i.re && reg_req_i.addr == a;
  endsequence
  sequence wr_s(a);
    ce_i && reg_req_i.we && reg_req_i.addr == a;
  endsequence
  oe_follow_a: assert property (wr_s(ADDR_RX_STATUS_CONTROL)
    |=> tx_pin_oe_o == $past(reg_req_i.wdata[7])) else $error("pin enable mismatch");
  irq_gate_a: assert property (tx_irq_o
    |-> irqc_q[IRQC_GLOBAL] && irqc_q[IRQC_PERIPH] && irqc_q[IRQC_TX])
    else $error("interrupt without enables");
  rdata_idle_a: assert property (ce_i && !reg_req_i.re |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  unmapped_a: assert property (ce_i && reg_req_i.re && reg_req_i.addr > ADDR_IRQ_STATUS
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  hold_read_a: assert property (rd_s(ADDR_TX_HOLDING_DATA) |=> reg_rdata_o == 8'h00)
    else $error("holding read not zero");
  busy_status_a: assert property (rd_s(ADDR_TX_STATUS_CONTROL) ##0 !tx_pin_o
    |=> !reg_rdata_o[TXSC_SHIFTER_EMPTY]) else $error("shifter empty while sending");
  off_idle_a: assert property (ce_i && !tx_pin_oe_o |=> tx_pin_o)
    else $error("line not idle with port off");
  off_flag_a: assert property (rd_s(ADDR_IRQ_STATUS)
    ##0 (!tx_pin_oe_o && !$past(tx_pin_oe_o) && $past(ce_i))
    |=> !reg_rdata_o[IRQS_TX_EMPTY]) else $error("flag set with port off");
endmodule

bind async_serial_transmitter tx_serial_sva chk (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .ce_i(ce_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .tx_pin_o(tx_pin_o),
  .tx_pin_oe_o(tx_pin_oe_o), .tx_irq_o(tx_irq_o));

// [tb/serial_rx_model.sv]
// Behavioural receiver standing at the far end of the serial line.
`timescale 1ns/1ps
module serial_rx_model (
  input  wire logic        sys_clk_i,
  input  wire logic        line_i,
  input  wire logic [15:0] period_i,
  input  wire logic        nine_i,
  output logic             got_o,
  output logic [9:0]       data_o
);
  logic [9:0] w;
  initial got_o = 1'b0;
  initial data_o = 10'h000;
  // Samples each bit in its middle; bit 9 of the result is the framing verdict.
  always begin
    @(negedge line_i);
    w = 10'h000;
    repeat (period_i / 2) @(posedge sys_clk_i);
    w[9] = ~line_i;
    for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
      repeat (period_i) @(posedge sys_clk_i);
      w[i] = line_i;
    end
    repeat (period_i) @(posedge sys_clk_i);
    w[9] = w[9] & line_i;
    got_o <= 1'b1;
    data_o <= w;
    @(posedge sys_clk_i);
    got_o <= 1'b0;
  end
endmodule

// [tb/tb.sv]
// Self-checking bench of the asynchronous serial transmitter.
`timescale 1ns/1ps
module tb;
  import tx_serial_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  reg_req_s   req = '0;
  logic [7:0] rdata, d, b;
  logic       pin, oe, irq, got, nine = 1'b0;
  logic       ce = 1'b1;
  logic [9:0] rxd;
  int         miscompares = 0, num_checks = 0, cyc = 0, per = 16;
  int         exp_q[$], got_q[$], when_q[$];
  wire        line = oe ? pin : 1'b1;
  always #25 sys_clk_i = ~sys_clk_i;
  async_serial_transmitter uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .reg_req_i(req), .reg_rdata_o(rdata), .tx_pin_o(pin), .tx_pin_oe_o(oe), .tx_irq_o(irq));
  serial_rx_model rx (.sys_clk_i(sys_clk_i), .line_i(line), .period_i(per[15:0]),
    .nine_i(nine), .got_o(got), .data_o(rxd));
  // Collects received characters and cuts a hang short.
  always @(posedge sys_clk_i) begin
    cyc++;
    if (got) begin
      got_q.push_back(rxd);
      when_q.push_back(cyc);
    end
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input int e, input logic [9:0] g);
    num_checks++;
    if (g !== e[9:0]) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    req <= '{a, v, 1'b1, 1'b0};
  endtask
  task automatic idle();
    @(posedge sys_clk_i);
    req <= '0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input int e);
    @(posedge sys_clk_i);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk_i);
    req <= '0;
    #1 chk($sformatf("reg %0d", a), e, {2'b00, rdata & m});
  endtask
  // Waits for n characters, then compares them and the back-to-back spacing.
  task automatic drain(input int n);
    while (got_q.size() < n) @(posedge sys_clk_i);
    repeat (per) @(posedge sys_clk_i);
    foreach (exp_q[i]) chk("char", exp_q[i], got_q[i][9:0]);
    chk("gap", 10 * per + nine * per, 10'(when_q[1] - when_q[0]));
    rchk(ADDR_TX_STATUS_CONTROL, 8'h02, 8'h02);
    exp_q.delete();
    got_q.delete();
    when_q.delete();
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hff1b));
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int a = 1; a < 16; a++) rchk(a[3:0], 8'hff, 0);
    d = 8'($urandom % 3);
    per = (d + 1) * 16;
    wr(ADDR_DIVISOR_LOW, d);
    wr(ADDR_DIVISOR_HIGH, 8'h05);
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(ADDR_TX_STATUS_CONTROL, 8'h24);
    idle();
    #1 chk("oe", 1, {9'h000, oe});
    rchk(ADDR_DIVISOR_LOW, 8'hff, d);
    rchk(ADDR_IRQ_STATUS, 8'h10, 8'h10);
    wr(ADDR_IRQ_CONTROL, 8'hd0);
    idle();
    #1 chk("irq", 1, {9'h000, irq});
    // writer drops the transmit interrupt enable before any character is written
    wr(ADDR_IRQ_CONTROL, 8'hc0);
    wr(ADDR_IRQ_STATUS, 8'h00);
    idle();
    #1 chk("irq", 0, {9'h000, irq});
    rchk(ADDR_IRQ_STATUS, 8'h10, 8'h10);
    for (int k = 0; k < 3; k++) begin
      b = 8'($urandom);
      wr(ADDR_TX_HOLDING_DATA, b);
      if (k < 2) exp_q.push_back(512 + b);
    end
    rchk(ADDR_IRQ_STATUS, 8'h10, 8'h00);
    rchk(ADDR_TX_STATUS_CONTROL, 8'h02, 8'h00);
    drain(2);
    d = 8'(4 + $urandom % 4);
    per = (d + 1) * 4;
    nine = 1'b1;
    wr(ADDR_BAUD_CONTROL, 8'h08);
    wr(ADDR_DIVISOR_HIGH, 8'h00);
    wr(ADDR_DIVISOR_LOW, d);
    for (int k = 0; k < 2; k++) begin
      b = 8'($urandom);
      wr(ADDR_TX_STATUS_CONTROL, 8'h64 | 8'(k));
      wr(ADDR_TX_HOLDING_DATA, b);
      exp_q.push_back(512 + 256 * k + b);
    end
    idle();
    drain(2);
    wr(ADDR_TX_HOLDING_DATA, 8'h00);
    repeat (3 * per) @(posedge sys_clk_i);
    wr(ADDR_RX_STATUS_CONTROL, 8'h00);
    idle();
    idle();
    #1 chk("pin", 1, {9'h000, pin});
    chk("oe", 0, {9'h000, oe});
    rchk(ADDR_IRQ_STATUS, 8'h10, 8'h00);
    repeat (12 * per) @(posedge sys_clk_i);
    got_q.delete();
    wr(ADDR_TX_STATUS_CONTROL, 8'h04);
    wr(ADDR_RX_STATUS_CONTROL, 8'h80);
    wr(ADDR_TX_HOLDING_DATA, 8'h00);
    idle();
    repeat (12 * per) @(posedge sys_clk_i);
    chk("frames", 0, 10'(got_q.size()));
    // A write made while the clock enable is low must leave no trace.
    @(posedge sys_clk_i);
    ce <= 1'b0;
    wr(ADDR_DIVISOR_LOW, 8'hff);
    @(posedge sys_clk_i);
    ce  <= 1'b1;
    req <= '0;
    rchk(ADDR_DIVISOR_LOW, 8'hff, d);
    report_and_stop();
  end
endmodule
